// [cod_pkg.sv]
// ==========================================================
// opcode decode types and constants
package cod_pkg;

    localparam logic [7:0] PREFIX_OPCODE = 8'h9E;
    localparam logic [2:0] MAX_OPERANDS  = 3'h3;
    localparam logic [3:0] FIRST_CYCLE   = 4'h1;
    localparam logic [7:0] ZERO_PAGE_HI  = 8'h00;
    localparam logic [15:0] AUTOINC_STEP = 16'h0001;

    typedef enum logic [4:0] {
        implied_mode,
        literal_mode,
        zero_page_mode,
        long_absolute_mode,
        index_mode,
        index_byte_offset_mode,
        index_word_offset_mode,
        stack_byte_offset_mode,
        stack_word_offset_mode,
        pc_offset_mode,
        index_autoinc_mode,
        index_byte_offset_autoinc_mode,
        index_autoinc_to_zero_page_move,
        zero_page_to_index_autoinc_move,
        literal_to_zero_page_move,
        zero_page_to_zero_page_move,
        zero_page_bit_branch_mode,
        literal_branch_mode
    } cod_mode_t;

    typedef struct packed {
        cod_mode_t  mode;
        logic [2:0] len;
        logic [3:0] cyc;
        logic       branch;
    } cod_dec_t;

    function automatic cod_dec_t mk(cod_mode_t m, logic [2:0] l,
                                    logic [3:0] c, logic b);
        cod_dec_t r;
        r.mode = m;
        r.len = l;
        r.cyc = c;
        r.branch = b;
        return r;
    endfunction

    // column from the high digit, row from the low digit
    function automatic cod_dec_t cod_decode(logic pre, logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        cod_dec_t   r;
        hi = op[7:4];
        lo = op[3:0];
        r = mk(implied_mode, 3'h1, 4'h1, 1'b0);
        if (pre) begin
            unique case (hi)
                4'h6: r = mk(stack_byte_offset_mode, 3'h3, 4'h5, 1'b0);
                4'hD: r = mk(stack_word_offset_mode, 3'h4, 4'h5, 1'b0);
                4'hE: r = mk(stack_byte_offset_mode, 3'h3, 4'h4, 1'b0);
                default: r = mk(implied_mode, 3'h2, 4'h2, 1'b0);
            endcase
        end else begin
            unique case (hi)
                4'h0: r = mk(zero_page_bit_branch_mode, 3'h3, 4'h5, 1'b1);
                4'h1: r = mk(zero_page_mode, 3'h2, 4'h4, 1'b0);
                4'h2: r = mk(pc_offset_mode, 3'h2, 4'h3, 1'b1);
                4'h3: r = mk(zero_page_mode, 3'h2, 4'h4, 1'b0);
                4'h4, 4'h5: begin
                    if (lo == 4'h1)
                        r = mk(literal_branch_mode, 3'h3, 4'h4, 1'b1);
                    else if (lo == 4'h5 && hi == 4'h4)
                        r = mk(literal_mode, 3'h3, 4'h3, 1'b0);
                    else if (lo == 4'h5)
                        r = mk(zero_page_mode, 3'h2, 4'h4, 1'b0);
                    else if (lo == 4'hE && hi == 4'h4)
                        r = mk(zero_page_to_zero_page_move, 3'h3, 4'h5, 1'b0);
                    else if (lo == 4'hE)
                        r = mk(zero_page_to_index_autoinc_move, 3'h2, 4'h4,
                               1'b0);
                    else if (lo == 4'h2)
                        r = mk(implied_mode, 3'h1, (hi == 4'h4) ? 4'h5 : 4'h7,
                               1'b0);
                end
                4'h6: begin
                    if (lo == 4'h1)
                        r = mk(index_byte_offset_autoinc_mode, 3'h3, 4'h5,
                               1'b1);
                    else if (lo == 4'h5)
                        r = mk(literal_mode, 3'h3, 4'h3, 1'b0);
                    else if (lo == 4'hE)
                        r = mk(literal_to_zero_page_move, 3'h3, 4'h4, 1'b0);
                    else
                        r = mk(index_byte_offset_mode, 3'h2, 4'h4, 1'b0);
                end
                4'h7: begin
                    if (lo == 4'h1)
                        r = mk(index_autoinc_mode, 3'h2, 4'h4, 1'b1);
                    else if (lo == 4'h5)
                        r = mk(zero_page_mode, 3'h2, 4'h4, 1'b0);
                    else if (lo == 4'hE)
                        r = mk(index_autoinc_to_zero_page_move, 3'h2, 4'h4,
                               1'b0);
                    else
                        r = mk(index_mode, 3'h1, 4'h3, 1'b0);
                end
                4'h8: begin
                    unique case (lo)
                        4'h0: r = mk(implied_mode, 3'h1, 4'h7, 1'b0);
                        4'h1: r = mk(implied_mode, 3'h1, 4'h4, 1'b0);
                        4'h3: r = mk(implied_mode, 3'h1, 4'h9, 1'b0);
                        4'hE: r = mk(implied_mode, 3'h1, 4'h1, 1'b0);
                        default: r = mk(implied_mode, 3'h1, 4'h2, 1'b0);
                    endcase
                end
                4'h9: begin
                    if (lo < 4'h4)
                        r = mk(pc_offset_mode, 3'h2, 4'h3, 1'b1);
                    else if (lo == 4'h4 || lo == 4'h5)
                        r = mk(implied_mode, 3'h1, 4'h2, 1'b0);
                    else if (lo == 4'hE)
                        r = mk(implied_mode, 3'h2, 4'h2, 1'b0);
                end
                4'hA: r = mk(literal_mode, 3'h2, 4'h2, 1'b0);
                4'hB: r = mk(zero_page_mode, 3'h2, 4'h3, 1'b0);
                4'hC: r = mk(long_absolute_mode, 3'h3, 4'h4, 1'b0);
                4'hD: r = mk(index_word_offset_mode, 3'h3, 4'h4, 1'b0);
                4'hE: r = mk(index_byte_offset_mode, 3'h2, 4'h3, 1'b0);
                4'hF: r = mk(index_mode, 3'h1, 4'h2, 1'b0);
            endcase
        end
        return r;
    endfunction

endpackage

// [cod_decode_seq.sv]
`timescale 1ns/1ns
// Summary of operation
// - The high hex digit picks the map column, the low digit the row.
// - Each opcode has a cycle count, length and mode, and runs that long.
// - Opcode 00 is bit-0 branch-if-high, zero page, 3 bytes, 5 cycles.
// - A prefixed byte-offset opcode adds one byte to the stack pointer.
// - A prefixed word-offset opcode adds 16 bits to the stack pointer.
// - Index byte-offset mode adds one unsigned byte to the index pair.
// - Word-offset mode adds a high-then-low offset to the index pair.
// - Long absolute mode fetches the address high byte then low byte.
// - Bit-test branches carry a zero-page address, then a signed offset.
// - Pc-offset branches add a signed byte to the pc when taken.
// - Index autoinc mode uses the index pair then increments it by one.
// - Byte-offset autoinc adds the offset, then increments the pair.
// - Move reads at the index pair, increments it, and writes zero page.
// - Zero-page-to-index move writes at the pair, then increments it.
// - Literal move stores an instruction byte at a zero-page address.
module cod_decode_seq (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic             clk_en_in,
    input  wire logic [7:0]       fetch_byte_in,
    input  wire logic [15:0]      index_in,
    input  wire logic [15:0]      sp_in,
    input  wire logic [15:0]      pc_in,
    input  wire logic             cond_in,
    output logic                  fetch_req_out,
    output logic                  done_out,
    output cod_pkg::cod_dec_t     dec_out,
    output logic [15:0]           ea_out,
    output logic [15:0]           ea2_out,
    output logic [7:0]            literal_out,
    output logic [15:0]           branch_target_out,
    output logic                  branch_take_out,
    output logic                  index_wr_out,
    output logic [15:0]           index_next_out
);

    typedef enum logic [1:0] {st_opcode, st_prefixed, st_run} cod_state_t;

    // ==========================================================
    // state
    cod_state_t        state_q;
    logic              pre_q;
    logic [2:0]        got_q;
    logic [3:0]        cnt_q;
    cod_pkg::cod_dec_t dec_q;
    logic [7:0]        opnd_q [3];

    // ==========================================================
    // decode of the byte now on the fetch port
    wire logic       is_prefix  = (state_q == st_opcode) &&
                                  (fetch_byte_in == cod_pkg::PREFIX_OPCODE);
    wire cod_pkg::cod_dec_t dec_now =
        (state_q == st_run) ? dec_q :
        cod_pkg::cod_decode(state_q == st_prefixed, fetch_byte_in);
    wire logic [3:0] cnt_now = (state_q == st_opcode) ? cod_pkg::FIRST_CYCLE
                                                      : cnt_q + 4'h1;
    // ends on the decoded count, never on the last byte fetched
    wire logic       last    = (cnt_now == dec_now.cyc) && !is_prefix;
    wire logic       take    = fetch_req_out;
    wire logic [2:0] got_now = got_q + {2'b00, take};
    wire logic [2:0] slot    = got_q - 3'h1 - {2'b00, pre_q};
    wire logic       next_req = last || (got_now < dec_now.len);

    // ==========================================================
    // operand bytes, with the byte arriving this cycle merged in
    logic [7:0] b [3];
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_opnd
            assign b[gi] = (take && state_q == st_run && slot == 3'(gi))
                           ? fetch_byte_in : opnd_q[gi];
        end
    endgenerate

    wire logic [15:0] zp0  = {cod_pkg::ZERO_PAGE_HI, b[0]};
    wire logic [15:0] zp1  = {cod_pkg::ZERO_PAGE_HI, b[1]};
    wire logic [15:0] word = {b[0], b[1]}; // high byte fetched first

    // ==========================================================
    // operand address selection
    function automatic logic [15:0] ea_sel(cod_pkg::cod_mode_t m);
        unique case (m)
            cod_pkg::zero_page_mode,
            cod_pkg::zero_page_bit_branch_mode,
            cod_pkg::zero_page_to_zero_page_move,
            cod_pkg::zero_page_to_index_autoinc_move: ea_sel = zp0;
            cod_pkg::long_absolute_mode:     ea_sel = word;
            cod_pkg::index_mode,
            cod_pkg::index_autoinc_mode,
            cod_pkg::index_autoinc_to_zero_page_move:
                ea_sel = index_in;
            cod_pkg::index_byte_offset_mode,
            cod_pkg::index_byte_offset_autoinc_mode:
                ea_sel = index_in + {8'h00, b[0]};
            cod_pkg::index_word_offset_mode: ea_sel = index_in + word;
            cod_pkg::stack_byte_offset_mode:
                ea_sel = sp_in + {8'h00, b[0]};
            cod_pkg::stack_word_offset_mode: ea_sel = sp_in + word;
            default:                         ea_sel = 16'h0000;
        endcase
    endfunction

    // destination address of the two-address moves
    function automatic logic [15:0] ea2_sel(cod_pkg::cod_mode_t m);
        unique case (m)
            cod_pkg::index_autoinc_to_zero_page_move: ea2_sel = zp0;
            cod_pkg::zero_page_to_index_autoinc_move:
                ea2_sel = index_in;
            cod_pkg::literal_to_zero_page_move,
            cod_pkg::zero_page_to_zero_page_move:     ea2_sel = zp1;
            default:                                  ea2_sel = 16'h0000;
        endcase
    endfunction

    // which operand byte is the branch displacement
    wire logic [7:0] disp =
        (dec_now.mode == cod_pkg::pc_offset_mode ||
         dec_now.mode == cod_pkg::index_autoinc_mode) ? b[0] : b[1];
    wire logic [15:0] target = pc_in + {{8{disp[7]}}, disp};
    wire logic autoinc =
        dec_now.mode == cod_pkg::index_autoinc_mode ||
        dec_now.mode == cod_pkg::index_byte_offset_autoinc_mode ||
        dec_now.mode == cod_pkg::index_autoinc_to_zero_page_move ||
        dec_now.mode == cod_pkg::zero_page_to_index_autoinc_move;

    // ==========================================================
    // sequencer: opcode, optional second opcode, operands, execute
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= st_opcode;
            pre_q   <= 1'b0;
            got_q   <= 3'h0;
            cnt_q   <= 4'h0;
            dec_q   <= '0;
            fetch_req_out <= 1'b1;
        end else if (clk_en_in) begin
            fetch_req_out <= next_req;
            cnt_q <= cnt_now;
            got_q <= last ? 3'h0 : got_now;
            pre_q <= is_prefix || (pre_q && !last);
            dec_q <= dec_now;
            state_q <= last      ? st_opcode :
                       is_prefix ? st_prefixed : st_run;
        end
    end

    // operand capture; stale slots beyond the length still reach literal_out and the target
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            opnd_q <= '{default: 8'h00};
        end else if (clk_en_in) begin
            opnd_q <= b;
        end
    end

    // ==========================================================
    // results, loaded on the final cycle of each instruction
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            done_out          <= 1'b0;
            dec_out           <= '0;
            ea_out            <= 16'h0000;
            ea2_out           <= 16'h0000;
            literal_out       <= 8'h00;
            branch_target_out <= 16'h0000;
            branch_take_out   <= 1'b0;
            index_wr_out      <= 1'b0;
            index_next_out    <= 16'h0000;
        end else if (clk_en_in) begin
            done_out <= last;
            if (last) begin
                dec_out           <= dec_now;
                ea_out            <= ea_sel(dec_now.mode);
                ea2_out           <= ea2_sel(dec_now.mode);
                literal_out       <= b[0];
                branch_target_out <= target;
                branch_take_out   <= dec_now.branch && cond_in;
                index_wr_out      <= autoinc;
                index_next_out    <= index_in + cod_pkg::AUTOINC_STEP;
            end
        end
    end

    // ==========================================================
    // checks
    a_column_select: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clk_en_in && state_q == st_opcode && fetch_byte_in[7:4] == 4'hC
        |-> dec_now.mode == cod_pkg::long_absolute_mode)
        else $error("high digit did not pick the column");
    // done shows one edge after the fifth cycle: five enabled edges
    a_opcode_zero: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clk_en_in && state_q == st_opcode && fetch_byte_in == 8'h00
        ##1 clk_en_in [*5] |-> done_out && dec_out.len == 3'h3 &&
        dec_out.cyc == 4'h5 &&
        dec_out.mode == cod_pkg::zero_page_bit_branch_mode)
        else $error("opcode zero not five cycles");
    a_stack_byte: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clk_en_in && last && dec_now.mode == cod_pkg::stack_byte_offset_mode
        |=> ea_out == $past(sp_in) + {8'h00, $past(b[0])})
        else $error("stack byte offset address wrong");
    a_stack_word: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clk_en_in && last && dec_now.mode == cod_pkg::stack_word_offset_mode
        |=> ea_out == $past(sp_in) + {$past(b[0]), $past(b[1])})
        else $error("stack word offset address wrong");
    // a frozen cycle holds done high with a stale count behind it
    a_done_count: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        done_out && $past(clk_en_in)
        |-> $past(cnt_now) == dec_out.cyc && fetch_req_out)
        else $error("instruction ended off its cycle count");
    a_long_absolute: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clk_en_in && last && dec_now.mode == cod_pkg::long_absolute_mode
        |=> ea_out == {$past(b[0]), $past(b[1])})
        else $error("long address byte order wrong");
    a_branch_target: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clk_en_in && last && dec_now.mode == cod_pkg::pc_offset_mode
        |=> branch_target_out ==
            $past(pc_in) + {{8{$past(b[0][7])}}, $past(b[0])}
        && branch_take_out == $past(cond_in))
        else $error("branch target or take wrong");
    a_autoinc_step: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clk_en_in && last && dec_now.mode == cod_pkg::index_autoinc_mode
        |=> index_wr_out && index_next_out == $past(index_in) + 16'h0001 &&
        ea_out == $past(index_in))
        else $error("autoinc index update wrong");
    a_move_to_index: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clk_en_in && last &&
        dec_now.mode == cod_pkg::zero_page_to_index_autoinc_move
        |=> ea2_out == $past(index_in) && index_wr_out)
        else $error("move destination not the index pair");

endmodule

// [cod_decode_seq_test.sv]
`timescale 1ns/1ns
module cod_decode_seq_test;

    // ==========================================================
    // signals
    typedef struct packed {
        logic [31:0]       b;
        logic [2:0]        nb;
        cod_pkg::cod_dec_t d;
        logic [15:0]       ea;
        logic [15:0]       ea2;
        logic [7:0]        lit;
        logic [15:0]       tgt;
        logic [3:0]        m;
    } cod_row_t;

    logic              ref_clk_in;
    logic              rst_in;
    logic              clk_en_in;
    logic [7:0]        fetch_byte_in;
    logic [15:0]       index_in;
    logic [15:0]       sp_in;
    logic [15:0]       pc_in;
    logic              cond_in;
    logic              fetch_req_out;
    logic              done_out;
    cod_pkg::cod_dec_t dec_out;
    logic [15:0]       ea_out;
    logic [15:0]       ea2_out;
    logic [7:0]        literal_out;
    logic [15:0]       branch_target_out;
    logic              branch_take_out;
    logic              index_wr_out;
    logic [15:0]       index_next_out;
    cod_row_t          t [20];
    int                err_total;
    int                n_tests;

    cod_decode_seq dut (
        .ref_clk_in        (ref_clk_in),
        .rst_in            (rst_in),
        .clk_en_in         (clk_en_in),
        .fetch_byte_in     (fetch_byte_in),
        .index_in          (index_in),
        .sp_in             (sp_in),
        .pc_in             (pc_in),
        .cond_in           (cond_in),
        .fetch_req_out     (fetch_req_out),
        .done_out          (done_out),
        .dec_out           (dec_out),
        .ea_out            (ea_out),
        .ea2_out           (ea2_out),
        .literal_out       (literal_out),
        .branch_target_out (branch_target_out),
        .branch_take_out   (branch_take_out),
        .index_wr_out      (index_wr_out),
        .index_next_out    (index_next_out)
    );

    // 4 ns clock
    always #2 ref_clk_in = ~ref_clk_in;

    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // m: bit0 ea, bit1 literal, bit2 branch target, bit3 autoinc
    function automatic cod_row_t rw(logic [31:0] b, logic [2:0] n,
        cod_pkg::cod_mode_t md, logic [2:0] l, logic [3:0] c, logic br,
        logic [15:0] ea, logic [15:0] ea2, logic [7:0] lit,
        logic [15:0] tg, logic [3:0] m);
        return '{b, n, '{md, l, c, br}, ea, ea2, lit, tg, m};
    endfunction

    // entered in the opcode cycle; filler bytes stand in for idle bus
    task automatic run_row(input cod_row_t r, input logic stall);
        int c;
        int k;
        c = 0;
        k = 1;
        fetch_byte_in = r.b[31:24];
        while (c < 16) begin
            @(posedge ref_clk_in);
            #1;
            c++;
            if (done_out === 1'b1) break;
            if (stall && c == 1) begin
                clk_en_in = 1'b0;
                repeat (3) @(posedge ref_clk_in);
                #1;
                chk(done_out, 1'b0);
                clk_en_in = 1'b1;
            end
            if (fetch_req_out === 1'b1 && k < r.nb) begin
                fetch_byte_in = r.b[31-8*k -: 8];
                k++;
            end else fetch_byte_in = 8'hA5;
        end
        chk(c, r.d.cyc);
        chk(dec_out, r.d);
        if (r.m[0]) chk(ea_out, r.ea);
        chk(ea2_out, r.ea2);
        if (r.m[1]) chk(literal_out, r.lit);
        if (r.m[2]) chk(branch_target_out, r.tgt);
        chk(branch_take_out, r.d.branch & cond_in);
        chk(index_wr_out, r.m[3]);
        if (r.m[3]) chk(index_next_out, index_in + 16'h0001);
    endtask

    // ==========================================================
    // tests
    // cut a hang short well past the expected hundred or so cycles
    initial begin
        #8000;
        err_total++;
        test_done;
    end

    initial begin
        ref_clk_in = 1'b0;
        rst_in = 1'b1;
        clk_en_in = 1'b1;
        fetch_byte_in = 8'h00;
        index_in = 16'h1200;
        sp_in = 16'h00F0;
        pc_in = 16'h0100;
        cond_in = 1'b1;
        err_total = 0;
        n_tests = 0;
        t[0] = rw(32'h0040_FE00, 3'h3, cod_pkg::zero_page_bit_branch_mode,
            3'h3, 4'h5, 1'b1, 16'h0040, 16'h0, 8'h0, 16'h00FE, 4'h5);
        t[1] = rw(32'hC612_3400, 3'h3, cod_pkg::long_absolute_mode,
            3'h3, 4'h4, 1'b0, 16'h1234, 16'h0, 8'h0, 16'h0, 4'h1);
        t[2] = rw(32'hD601_0200, 3'h3, cod_pkg::index_word_offset_mode,
            3'h3, 4'h4, 1'b0, 16'h1302, 16'h0, 8'h0, 16'h0, 4'h1);
        t[3] = rw(32'hE6FF_0000, 3'h2, cod_pkg::index_byte_offset_mode,
            3'h2, 4'h3, 1'b0, 16'h12FF, 16'h0, 8'h0, 16'h0, 4'h1);
        t[4] = rw(32'h9EE6_1000, 3'h3, cod_pkg::stack_byte_offset_mode,
            3'h3, 4'h4, 1'b0, 16'h0100, 16'h0, 8'h0, 16'h0, 4'h1);
        t[5] = rw(32'h9E66_0500, 3'h3, cod_pkg::stack_byte_offset_mode,
            3'h3, 4'h5, 1'b0, 16'h00F5, 16'h0, 8'h0, 16'h0, 4'h1);
        t[6] = rw(32'h9ED6_0100, 3'h4, cod_pkg::stack_word_offset_mode,
            3'h4, 4'h5, 1'b0, 16'h01F0, 16'h0, 8'h0, 16'h0, 4'h1);
        t[7] = rw(32'h2080_0000, 3'h2, cod_pkg::pc_offset_mode,
            3'h2, 4'h3, 1'b1, 16'h0, 16'h0, 8'h0, 16'h0080, 4'h4);
        t[8] = rw(32'h7105_0000, 3'h2, cod_pkg::index_autoinc_mode,
            3'h2, 4'h4, 1'b1, 16'h1200, 16'h0, 8'h0, 16'h0105, 4'hD);
        t[9] = rw(32'h6133_0700, 3'h3,
            cod_pkg::index_byte_offset_autoinc_mode,
            3'h3, 4'h5, 1'b1, 16'h1233, 16'h0, 8'h0, 16'h0107, 4'hD);
        t[10] = rw(32'h7E50_0000, 3'h2,
            cod_pkg::index_autoinc_to_zero_page_move,
            3'h2, 4'h4, 1'b0, 16'h1200, 16'h0050, 8'h0, 16'h0, 4'h9);
        t[11] = rw(32'h5E60_0000, 3'h2,
            cod_pkg::zero_page_to_index_autoinc_move,
            3'h2, 4'h4, 1'b0, 16'h0060, 16'h1200, 8'h0, 16'h0, 4'h9);
        t[12] = rw(32'h6EAB_7000, 3'h3, cod_pkg::literal_to_zero_page_move,
            3'h3, 4'h4, 1'b0, 16'h0, 16'h0070, 8'hAB, 16'h0, 4'h2);
        t[13] = rw(32'h8300_0000, 3'h1, cod_pkg::implied_mode,
            3'h1, 4'h9, 1'b0, 16'h0, 16'h0, 8'h0, 16'h0, 4'h0);
        t[14] = rw(32'h9600_0000, 3'h1, cod_pkg::implied_mode,
            3'h1, 4'h1, 1'b0, 16'h0, 16'h0, 8'h0, 16'h0, 4'h0);
        t[15] = rw(32'hA65A_0000, 3'h2, cod_pkg::literal_mode,
            3'h2, 4'h2, 1'b0, 16'h0, 16'h0, 8'h5A, 16'h0, 4'h2);
        t[16] = rw(32'hB680_0000, 3'h2, cod_pkg::zero_page_mode,
            3'h2, 4'h3, 1'b0, 16'h0080, 16'h0, 8'h0, 16'h0, 4'h1);
        t[17] = rw(32'hF600_0000, 3'h1, cod_pkg::index_mode,
            3'h1, 4'h2, 1'b0, 16'h1200, 16'h0, 8'h0, 16'h0, 4'h1);
        t[18] = rw(32'h4E30_4000, 3'h3, cod_pkg::zero_page_to_zero_page_move,
            3'h3, 4'h5, 1'b0, 16'h0030, 16'h0040, 8'h0, 16'h0, 4'h1);
        t[19] = rw(32'h4120_F000, 3'h3, cod_pkg::literal_branch_mode,
            3'h3, 4'h4, 1'b1, 16'h0, 16'h0, 8'h20, 16'h00F0, 4'h6);
        repeat (5) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        chk(fetch_req_out, 1'b1);
        chk(done_out, 1'b0);
        chk(dec_out, 13'h0000);
        // back to back through the table
        for (int i = 0; i < 20; i++) begin
            run_row(t[i], 1'b0);
        end
        // branches with the condition false must not be taken
        cond_in = 1'b0;
        run_row(t[0], 1'b0);
        run_row(t[7], 1'b0);
        cond_in = 1'b1;
        // disabled cycles must not count toward the cycle total
        run_row(t[1], 1'b1);
        // reset in mid-instruction, then a clean restart
        fetch_byte_in = 8'hC6;
        @(posedge ref_clk_in);
        #1;
        fetch_byte_in = 8'h12;
        rst_in = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        chk(fetch_req_out, 1'b1);
        chk(done_out, 1'b0);
        chk(ea_out, 16'h0000);
        run_row(t[1], 1'b0);
        run_row(t[6], 1'b0);
        test_done;
    end

endmodule
